// ### include/pump_lock_defs.svh
/*
  offsets, field positions, reset values and timing counts for the
  pump, lock detect and output configuration register bank.
  assumes: included by bare name from design files.
*/
`ifndef PUMP_LOCK_DEFS_SVH
`define PUMP_LOCK_DEFS_SVH

// register indexes; byte address is four times the index
`define MULTIPLIER_SETTLE_COUNT_OUT_IDX      8'h23
`define LOCK_DETECT_IDX        8'h27
`define PUMP_UP_GAIN_IDX       8'h28
`define STATUS_IDX             8'h30
`define MULTIPLIER_SETTLE_COUNT_OUT_ADDR     12'h08C
`define LOCK_DETECT_ADDR       12'h09C
`define PUMP_UP_GAIN_ADDR      12'h0A0
`define STATUS_ADDR            12'h0C0

// reset values
`define MULTIPLIER_SETTLE_COUNT_OUT_RST      16'h0647
`define LOCK_DETECT_RST        16'h11F0
`define PUMP_UP_GAIN_RST       16'h101C

// field positions
`define PUMP_UP_MSB            12
`define PUMP_UP_LSB            8
`define PUMP_GAIN_MSB          7
`define PUMP_GAIN_LSB          6
`define STATUS_SEL_BIT         3
`define LOCK_EN_BIT            0
`define SETTLE_MSB             13
`define SETTLE_LSB             3
`define AUTOMUTE_BIT           2
`define TX_TYPE_BIT            1
`define RX_TYPE_BIT            0

// pump current step in nanoamps (156.25 uA)
`define PUMP_STEP_NA           32'd156250
// multiplier settle time the count must cover, in ns, and cycles at 100 MHz
`define SETTLE_HINT_NS         20000
`define SETTLE_HINT_CYC        (`SETTLE_HINT_NS / 10)

`endif

// ### include/pump_lock_pkg.sv
/*
  types shared by the pump, lock detect and output register bank.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package pump_lock_pkg;

  typedef struct packed {
    logic [15:0] multiplier_settle_count_out;
    logic [15:0] lock_detect;
    logic [15:0] pump_up_gain;
  } cfg_regs_s;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_SETTLE,
    SW_LOCKWAIT
  } switch_state_e;

  typedef struct packed {
    logic        tri_state;
    logic [4:0]  up_code;
    logic [5:0]  base_sum;
    logic [1:0]  gain_code;
    logic [9:0]  scaled_half;
  } pump_ctrl_s;

endpackage

// ### rtl/settle_counter.sv
/*
  settling counter: counts reference cycles up to a programmed length.
  assumes: start is a one-cycle pulse on the reference clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pump_lock_defs.svh"

module settle_counter
  import pump_lock_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // control
  input  wire logic        start,
  input  wire logic [10:0] length,
  // status
  output logic             busy,
  output logic             done
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [10:0] count;
  } settle_s;

  settle_s state_reg;
  settle_s state_next;

  // count once per cycle; zero length finishes at once
  always_comb
  begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (start)
    begin
      state_next.count = 11'h001;
      if (length == 11'h000)
      begin
        state_next.busy = 1'b0; // [RULE10]
        state_next.done = 1'b1;
      end
      else
      begin
        state_next.busy = 1'b1; // [RULE17]
      end
    end
    else if (state_reg.busy)
    begin
      if (state_reg.count >= length)
      begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1; // [RULE17]
      end
      else
      begin
        state_next.count = state_reg.count + 11'h001;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;

endmodule
`default_nettype wire

// ### rtl/pump_current_calc.sv
/*
  pump current decode: tri-state flag and scaled current in half steps.
  assumes: codes come straight from configuration flops.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pump_lock_defs.svh"

module pump_current_calc
  import pump_lock_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // codes
  input  wire logic [4:0] up_code,
  input  wire logic [4:0] down_code,
  input  wire logic [1:0] gain_code,
  // result
  output pump_ctrl_s      pump_ctrl
);

  pump_ctrl_s state_reg;
  pump_ctrl_s state_next;
  logic [5:0] base;

  // scaled current = base * gain, in half steps of 156.25 uA
  always_comb
  begin
    base                   = {1'b0, up_code} + {1'b0, down_code};
    state_next             = state_reg;
    state_next.tri_state   = (up_code == 5'h00); // [RULE2]
    state_next.up_code     = up_code;
    state_next.base_sum    = base; // [RULE3]
    state_next.gain_code   = gain_code;
    case (gain_code) // [RULE4]
      2'd0:    state_next.scaled_half = {3'b000, base, 1'b0};
      2'd1:    state_next.scaled_half = {2'b00, base, 2'b00};
      2'd2:    state_next.scaled_half = 10'({3'b000, base, 1'b0})
                                       + 10'({4'b0000, base});
      2'd3:    state_next.scaled_half = 10'({2'b00, base, 2'b00})
                                       + 10'({4'b0000, base});
      default: state_next.scaled_half = '0;
    endcase
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign pump_ctrl = state_reg;

endmodule
`default_nettype wire

// ### rtl/pump_lock_output_cfg_regs.sv
/*
  configuration bank for pump current, status pin, lock detect,
  multiplier settling wait, output automute and output drive type,
  reached over AXI4-Lite.
  assumes: core_clk is the reference input clock; loop_locked,
  switch requests and readback data come from other device logic
  on the same clock, pump_down_current_code from the adjoining bank.
*/
// Register access over AXI4-Lite was left to the implementer.
// Overview of operation
// [RULE1] software writes pump register reserved bits as 0 above, 1Ch below
// [RULE2] pump-up code 12..8 tri-states at zero, 156.25 uA per step
// [RULE3] software keeps pump-down equal to pump-up; base is their sum
// [RULE4] gain bits 7..6 scale base: 1x, 2x, 1.5x, 2.5x
// [RULE5] software writes 11Fh into lock-detect register bits 15..4
// [RULE6] software writes 1 into lock-detect register bits 2..1
// [RULE7] bit 3 picks status pin: readback data or lock detect
// [RULE8] lock detect works only while bit 0 is one
// [RULE9] software writes zero into output register bits 15..14
// [RULE10] settle count 13..3 in reference cycles; zero skips the wait
// [RULE11] software sets settle count to cover 20 us with multiplier on
// [RULE12] every frequency switch includes the settle wait
// [RULE13] automute holds both outputs muted until lock after each event
// [RULE14] lock lost after release does not mute outputs again
// [RULE15] bit 1: transmit output open-drain at zero, push-pull at one
// [RULE16] bit 0: receive output open-drain at zero, push-pull at one
// [RULE17] settle counter starts on switch, counts cycles, flags done
// [RULE18] registers reset to documented values and hold writes
`timescale 1ns/10ps
`default_nettype none
`include "pump_lock_defs.svh"

module pump_lock_output_cfg_regs
  import pump_lock_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // loop events from the synthesizer core
  input  wire logic        init_start,
  input  wire logic        vco_change,
  input  wire logic        profile_switch,
  input  wire logic        loop_locked,
  input  wire logic        readback_data,
  input  wire logic [4:0]  pump_down_current_code,
  // outputs to the analog core
  output pump_ctrl_s       pump_ctrl,
  output logic             status_pin,
  output logic             lock_detect_out,
  output logic             settle_busy,
  output logic             settle_done,
  output logic             output_muted,
  output logic             tx_output_drive_type,
  output logic             rx_output_drive_type
);

  typedef struct packed {
    cfg_regs_s     cfg;
    logic          aw_held;
    logic [11:0]   aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    switch_state_e sw;
    logic          muted;
    logic          armed;
    logic          status;
    logic          lock_out;
  } bank_s;

  bank_s       state_reg;
  bank_s       state_next;
  logic        switch_req;
  logic        settle_start;
  logic        s_busy;
  logic        s_done;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;
  logic        do_write;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        aw_have;
  logic        w_have;
  logic [11:0] aw_sel;
  logic [1:0]  strb_sel;

  // any of the three events begins a frequency switch
  assign switch_req   = init_start | vco_change | profile_switch;
  assign settle_start = switch_req; // [RULE12]

  // settling wait on every switch
  settle_counter u_settle (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (settle_start),
    .length   (state_reg.cfg.multiplier_settle_count_out[`SETTLE_MSB:`SETTLE_LSB]),
    .busy     (s_busy),
    .done     (s_done)
  );

  // pump current decode
  pump_current_calc u_pump (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .up_code   (state_reg.cfg.pump_up_gain[`PUMP_UP_MSB:`PUMP_UP_LSB]),
    .down_code (pump_down_current_code),
    .gain_code (state_reg.cfg.pump_up_gain[`PUMP_GAIN_MSB:`PUMP_GAIN_LSB]),
    .pump_ctrl (pump_ctrl)
  );

  // held half, else the one offered now; never fed back from state_next
  assign aw_have  = state_reg.aw_held | s_axi_awvalid;
  assign w_have   = state_reg.w_held | s_axi_wvalid;
  assign aw_sel   = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
  assign strb_sel = state_reg.w_held ? state_reg.w_strb[1:0]
                                     : s_axi_wstrb[1:0];
  // write strobes: byte lanes 0 and 1 carry the 16-bit register
  assign wr_mask = {{8{strb_sel[1]}}, {8{strb_sel[0]}}};
  assign wr_val  = state_reg.w_held ? state_reg.w_data[15:0]
                                    : s_axi_wdata[15:0];
  assign do_write = aw_have && w_have && !state_reg.bvalid;
  assign wr_hit = (aw_sel == `MULTIPLIER_SETTLE_COUNT_OUT_ADDR)
                  || (aw_sel == `LOCK_DETECT_ADDR)
                  || (aw_sel == `PUMP_UP_GAIN_ADDR);

  // read decode; status word shows lock state of this block
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `MULTIPLIER_SETTLE_COUNT_OUT_ADDR: rd_val = {16'h0000, state_reg.cfg.multiplier_settle_count_out};
      `LOCK_DETECT_ADDR:   rd_val = {16'h0000, state_reg.cfg.lock_detect};
      `PUMP_UP_GAIN_ADDR:  rd_val = {16'h0000, state_reg.cfg.pump_up_gain};
      `STATUS_ADDR:        rd_val = {27'h000_0000, state_reg.lock_out,
                                     state_reg.muted, s_busy,
                                     state_reg.sw == SW_LOCKWAIT,
                                     pump_ctrl.tri_state};
      default:             rd_hit = 1'b0;
    endcase
  end

  // bus channels, configuration and mute sequencing
  always_comb
  begin
    state_next = state_reg;
    // capture address and data in either order
    if (s_axi_awvalid && !state_reg.aw_held)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    // write completes once both halves are held or offered, with no response pending
    if (do_write)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = wr_hit ? 2'b00 : 2'b10;
      case (aw_sel) // [RULE18]
        `MULTIPLIER_SETTLE_COUNT_OUT_ADDR:
          state_next.cfg.multiplier_settle_count_out = (state_reg.cfg.multiplier_settle_count_out
                                          & ~wr_mask) | (wr_val & wr_mask);
        `LOCK_DETECT_ADDR:
          state_next.cfg.lock_detect = (state_reg.cfg.lock_detect
                                        & ~wr_mask) | (wr_val & wr_mask);
        `PUMP_UP_GAIN_ADDR:
          state_next.cfg.pump_up_gain = (state_reg.cfg.pump_up_gain
                                         & ~wr_mask) | (wr_val & wr_mask);
        default: ;
      endcase
    end
    // read answer one cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    if (s_axi_arvalid && !state_reg.rvalid)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_val;
      state_next.rresp  = rd_hit ? 2'b00 : 2'b10;
    end

    // lock detect output gated by its enable
    state_next.lock_out = state_reg.cfg.lock_detect[`LOCK_EN_BIT]
                          & loop_locked; // [RULE8]
    // status pin source select
    state_next.status = state_reg.cfg.lock_detect[`STATUS_SEL_BIT]
                        ? state_next.lock_out : readback_data; // [RULE7]

    // switch sequence: settle wait, then wait for lock
    case (state_reg.sw)
      SW_IDLE:
        if (switch_req)
          state_next.sw = SW_SETTLE;
      SW_SETTLE:
        if (s_done)
          state_next.sw = SW_LOCKWAIT;
      SW_LOCKWAIT:
        if (switch_req)
          state_next.sw = SW_SETTLE;
        else if (loop_locked)
          state_next.sw = SW_IDLE;
      default:
        state_next.sw = SW_IDLE;
    endcase
    // mute on each event while automute set, release at lock
    if (switch_req)
    begin
      state_next.armed = 1'b1;
      state_next.muted = state_reg.cfg.multiplier_settle_count_out[`AUTOMUTE_BIT];
    end
    else if (state_reg.sw == SW_LOCKWAIT && loop_locked)
    begin
      state_next.armed = 1'b0;
      state_next.muted = 1'b0; // [RULE13]
    end
    else if (!state_reg.armed)
    begin
      state_next.muted = 1'b0; // [RULE14]
    end
    if (!state_reg.cfg.multiplier_settle_count_out[`AUTOMUTE_BIT])
      state_next.muted = 1'b0;
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_reg                  <= '0;
      state_reg.cfg.multiplier_settle_count_out <= `MULTIPLIER_SETTLE_COUNT_OUT_RST; // [RULE18]
      state_reg.cfg.lock_detect  <= `LOCK_DETECT_RST;
      state_reg.cfg.pump_up_gain <= `PUMP_UP_GAIN_RST;
      state_reg.sw               <= SW_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bus outputs
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready  = !state_reg.w_held;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

  // block outputs
  assign status_pin           = state_reg.status;
  assign lock_detect_out      = state_reg.lock_out;
  assign settle_busy          = s_busy;
  assign settle_done          = s_done;
  assign output_muted         = state_reg.muted;
  assign tx_output_drive_type =
    state_reg.cfg.multiplier_settle_count_out[`TX_TYPE_BIT]; // [RULE15]
  assign rx_output_drive_type =
    state_reg.cfg.multiplier_settle_count_out[`RX_TYPE_BIT]; // [RULE16]

endmodule
`default_nettype wire

// ### verification/pump_lock_output_cfg_regs_sva.sv
/*
  checker for the pump, lock detect and output bank ports.
  assumes: bound to the top module; one clock, rst_b active low.
*/
`timescale 1ns/10ps
`default_nettype none

module pump_lock_output_cfg_regs_sva
  import pump_lock_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // write response
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // loop events
  input wire logic       init_start,
  input wire logic       vco_change,
  input wire logic       profile_switch,
  input wire logic       loop_locked,
  input wire logic       readback_data,
  input wire logic [4:0] pump_down_current_code,
  // outputs
  input wire pump_ctrl_s pump_ctrl,
  input wire logic       status_pin,
  input wire logic       lock_detect_out,
  input wire logic       settle_busy,
  input wire logic       settle_done,
  input wire logic       output_muted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // any event that starts a switch, and the gain in half steps
  wire logic       sw_ev = init_start | vco_change | profile_switch;
  wire logic [2:0] mul   = (pump_ctrl.gain_code == 2'h0) ? 3'h2 :
                           (pump_ctrl.gain_code == 2'h1) ? 3'h4 :
                           (pump_ctrl.gain_code == 2'h2) ? 3'h3 : 3'h5;

  // pump decode, relative to the previous cycle's codes
  pump_tri_a: assert property ($past(rst_b) |->
    pump_ctrl.tri_state == (pump_ctrl.up_code == 5'h00))
    else $error("pump tri-state flag wrong");
  pump_scale_a: assert property ($past(rst_b) |->
    pump_ctrl.scaled_half == pump_ctrl.base_sum * mul)
    else $error("scaled pump current wrong");
  pump_base_a: assert property ($past(rst_b) |->
    pump_ctrl.base_sum == {1'b0, pump_ctrl.up_code}
                          + {1'b0, $past(pump_down_current_code)})
    else $error("base pump sum wrong");
  // lock detect and status pin
  lock_off_a: assert property (!$past(loop_locked) |->
    !lock_detect_out) else $error("lock detect high without lock");
  status_src_a: assert property ($past(rst_b) |->
    status_pin == $past(readback_data) || status_pin == lock_detect_out
    || status_pin == $past(lock_detect_out))
    else $error("status pin from no source");
  // cycles the settle counter has stood busy since its last start
  logic [11:0] busy_cnt;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || sw_ev || !settle_busy)
      busy_cnt <= 12'h000;
    else
      busy_cnt <= busy_cnt + 12'h001;
  end

  // settling counter
  settle_go_a: assert property (sw_ev |=>
    settle_busy || settle_done) else $error("settle did not start");
  settle_end_a: assert property (settle_busy |->
    busy_cnt < 12'h7FF) else $error("settle never done");
  settle_fall_a: assert property ($fell(settle_busy) |->
    settle_done) else $error("settle ended without done");
  // muting and write response
  no_remute_a: assert property ($rose(output_muted) |->
    $past(sw_ev)) else $error("mute without switch event");
  mute_hold_a: assert property (output_muted && !loop_locked
    |=> output_muted) else $error("unmuted before lock");
  bresp_ok_a: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("illegal write response");

  // main scenarios
  cover property (sw_ev ##1 settle_busy);
  cover property (settle_done);
  cover property ($fell(output_muted));
endmodule

`default_nettype wire

// ### verification/testbench.sv
/*
  self-checking bench for the pump, lock detect and output bank.
  assumes: package, defs header and design compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pump_lock_defs.svh"

module testbench
  import pump_lock_pkg::*;
;
  // inputs
  logic        core_clk = 1'b0, rst_b = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        init_start = 1'b0, vco_change = 1'b0;
  logic        profile_switch = 1'b0, loop_locked = 1'b0;
  logic        readback_data = 1'b0;
  logic [4:0]  pump_down_current_code = 5'h10;
  // outputs and bench state
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  pump_ctrl_s  pump_ctrl;
  logic        status_pin, lock_detect_out, settle_busy, settle_done;
  logic        output_muted, tx_output_drive_type, rx_output_drive_type;
  int          n_errors = 0, checked = 0, cycles = 0;

  pump_lock_output_cfg_regs i_pump_lock_output_cfg_regs (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .init_start(init_start), .vco_change(vco_change),
    .profile_switch(profile_switch), .loop_locked(loop_locked),
    .readback_data(readback_data),
    .pump_down_current_code(pump_down_current_code),
    .pump_ctrl(pump_ctrl), .status_pin(status_pin),
    .lock_detect_out(lock_detect_out), .settle_busy(settle_busy),
    .settle_done(settle_done), .output_muted(output_muted),
    .tx_output_drive_type(tx_output_drive_type),
    .rx_output_drive_type(rx_output_drive_type));

  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write: address and data offered together, released when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read
  task automatic rdr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_check(input logic [11:0] a, input logic [15:0] e);
    rdr(a, rd, rsp);
    check(rd, {16'h0000, e});
  endtask

  task automatic t_reset();
    rd_check(`MULTIPLIER_SETTLE_COUNT_OUT_ADDR, `MULTIPLIER_SETTLE_COUNT_OUT_RST);
    rd_check(`LOCK_DETECT_ADDR, `LOCK_DETECT_RST);
    rd_check(`PUMP_UP_GAIN_ADDR, `PUMP_UP_GAIN_RST);
    check(tx_output_drive_type, 1'b1);
    check(rx_output_drive_type, 1'b1);
    check(pump_ctrl.up_code, 5'h10);
    $display("test reset done");
  endtask

  // every gain code at zero, one and full pump code
  task automatic t_pump();
    logic [4:0]  codes [3] = '{5'h00, 5'h01, 5'h1F};
    logic [2:0]  mul [4]   = '{3'h2, 3'h4, 3'h3, 3'h5};
    logic [15:0] v;
    for (int i = 0; i < 3; i++)
      for (int g = 0; g < 4; g++)
      begin
        v = {3'h0, codes[i], g[1:0], 6'h1C};
        pump_down_current_code <= codes[i];
        wr(`PUMP_UP_GAIN_ADDR, v, 4'h3, rsp);
        repeat (2) @(posedge core_clk);
        #1;
        check(pump_ctrl.tri_state, codes[i] == 5'h00);
        check(pump_ctrl.scaled_half, 2 * codes[i] * mul[g]);
        rd_check(`PUMP_UP_GAIN_ADDR, v);
      end
    $display("test pump done");
  endtask

  // status pin source and lock detect enable, all four settings
  task automatic t_lock();
    logic [15:0] v;
    loop_locked <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      v = {12'h11F, k[1], 2'h1, k[0]};
      readback_data <= !k[0];
      wr(`LOCK_DETECT_ADDR, v, 4'h3, rsp);
      repeat (3) @(posedge core_clk);
      #1;
      check(lock_detect_out, k[0]);
      check(status_pin, k[1] ? k[0] : !k[0]);
    end
    loop_locked <= 1'b0;
    $display("test lock done");
  endtask

  // each switch event waits the settle count, then mutes until lock
  task automatic t_settle();
    logic [15:0] v;
    logic [10:0] len;
    int          n;
    for (int i = 0; i < 5; i++)
    begin
      len = (i == 3) ? 11'h000 : (i == 4) ? 11'(`SETTLE_HINT_CYC)
                                          : 11'h005;
      v = {2'h0, len, 1'b1, i[0], !i[0]};
      wr(`MULTIPLIER_SETTLE_COUNT_OUT_ADDR, v, 4'h3, rsp);
      #1;
      check(tx_output_drive_type, i[0]);
      check(rx_output_drive_type, !i[0]);
      @(posedge core_clk);
      init_start     <= (i % 3 == 0);
      vco_change     <= (i % 3 == 1);
      profile_switch <= (i % 3 == 2);
      @(posedge core_clk);
      init_start     <= 1'b0;
      vco_change     <= 1'b0;
      profile_switch <= 1'b0;
      #1;
      n = 0;
      while (settle_done !== 1'b1 && n < 3000)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      check(n, len);
      check(output_muted, 1'b1);
      rdr(`STATUS_ADDR, rd, rsp);
      check(rd, 32'h0000_000A);
      loop_locked <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check(output_muted, 1'b0);
      loop_locked <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check(output_muted, 1'b0);
    end
    $display("test settle done");
  endtask

  // unmapped place and a low-lane-only write
  task automatic t_bus();
    wr(12'h0C4, 16'h1234, 4'h3, rsp);
    check(rsp, 2'h2);
    rdr(12'h0C4, rd, rsp);
    check(rd, 32'h0000_0000);
    check(rsp, 2'h2);
    wr(`PUMP_UP_GAIN_ADDR, 16'hAA5C, 4'h1, rsp);
    rd_check(`PUMP_UP_GAIN_ADDR, 16'h1F5C);
    $display("test bus done");
  endtask

  // reset for two cycles, then the tests in turn
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_pump();
    t_lock();
    t_settle();
    t_bus();
    print_verdict();
  end
endmodule

bind pump_lock_output_cfg_regs pump_lock_output_cfg_regs_sva
  i_pump_lock_output_cfg_regs_sva (
  .core_clk(core_clk), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .init_start(init_start),
  .vco_change(vco_change), .profile_switch(profile_switch),
  .loop_locked(loop_locked), .readback_data(readback_data),
  .pump_down_current_code(pump_down_current_code),
  .pump_ctrl(pump_ctrl), .status_pin(status_pin),
  .lock_detect_out(lock_detect_out), .settle_busy(settle_busy),
  .settle_done(settle_done), .output_muted(output_muted));

`default_nettype wire
